// ---- design/nfhc_cfg.svh ----
// Constants of the NOR flash host controller: unlock addresses, command
// codes, limits and bus timing. Included by the package and both modules.
`ifndef NFHC_CFG_SVH
`define NFHC_CFG_SVH
`define NFHC_ADDR_W 24
`define NFHC_DATA_W 16
// Unlock addresses per bus width
`define NFHC_U1_X16 24'h00_0555
`define NFHC_U2_X16 24'h00_02AA
`define NFHC_U1_X8 24'h00_0AAA
`define NFHC_U2_X8 24'h00_0555
// Command codes
`define NFHC_C_UNLK1 8'hAA
`define NFHC_C_UNLK2 8'h55
`define NFHC_C_RESET 8'hF0
`define NFHC_C_CFI 8'h98
`define NFHC_C_ASEL 8'h90
`define NFHC_C_BYP 8'h20
`define NFHC_C_BYPX0 8'h90
`define NFHC_C_BYPX1 8'h00
`define NFHC_C_PROG 8'hA0
`define NFHC_C_BUF 8'h25
`define NFHC_C_CONF 8'h29
`define NFHC_C_ERASE 8'h80
`define NFHC_C_CHIP 8'h10
`define NFHC_C_BLOCK 8'h30
`define NFHC_C_SUSP 8'hB0
`define NFHC_C_RESUME 8'h30
`define NFHC_C_EXT 8'hEB
`define NFHC_C_BLANK 8'h76
`define NFHC_C_ZERO 8'h00
// Buffer count limits (units minus one) and in-page address masks
`define NFHC_BUF_MAX_X8 9'h0FF
`define NFHC_BUF_MAX_X16 9'h1FF
`define NFHC_PAGE_MASK_X8 24'h00_00FF
`define NFHC_PAGE_MASK_X16 24'h00_01FF
// Status bit that reports a buffered program abort
`define NFHC_ABORT_BIT 1
// Bus timing in ns
`define NFHC_CLK_NS 10
`define NFHC_T_SETUP_NS 20
`define NFHC_T_WP_NS 40
`define NFHC_T_HOLD_NS 20
`define NFHC_T_ACC_NS 80
`endif

// ---- design/nfhc_pkg.sv ----
// Types of the NOR flash host controller: commands, modes, carriers.
// Widths come from nfhc_cfg.svh.
`include "nfhc_cfg.svh"
package nfhc_pkg;
  typedef enum logic [3:0] {
    NFHC_RESET = 4'h0,
    NFHC_CFI = 4'h1,
    NFHC_ASEL = 4'h2,
    NFHC_BYP_ENTER = 4'h3,
    NFHC_BYP_EXIT = 4'h4,
    NFHC_PROGRAM = 4'h5,
    NFHC_BUF_PROG = 4'h6,
    NFHC_CHIP_ERASE = 4'h7,
    NFHC_BLOCK_ERASE = 4'h8,
    NFHC_ERASE_MORE = 4'h9,
    NFHC_SUSPEND = 4'hA,
    NFHC_RESUME = 4'hB,
    NFHC_BLANK = 4'hC,
    NFHC_READ = 4'hD
  } nfhc_cmd_e;
  // Device mode as the host believes it to be
  typedef enum logic [1:0] {
    NFHC_M_ARRAY = 2'b00,
    NFHC_M_ASEL = 2'b01,
    NFHC_M_CFI = 2'b10
  } nfhc_mode_e;
  typedef struct packed {
    nfhc_cmd_e cmd;
    logic [`NFHC_ADDR_W-1:0] addr;
    logic [`NFHC_DATA_W-1:0] data;
    logic [8:0] count;
  } nfhc_req_s;
  typedef struct packed {
    logic rd;
    logic [`NFHC_ADDR_W-1:0] addr;
    logic [`NFHC_DATA_W-1:0] data;
  } nfhc_cyc_s;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`NFHC_ADDR_W-1:0] addr;
    logic [`NFHC_DATA_W-1:0] dq_out;
    logic dq_oe;
  } nfhc_pins_s;
endpackage

// ---- design/nfhc_bus_cycle.sv ----
// One asynchronous flash bus cycle, read or write, timed in clk cycles.
// Assumes dq_in comes from the pins, outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "nfhc_cfg.svh"
module nfhc_bus_cycle #(
  parameter int SETUP_CYC = (`NFHC_T_SETUP_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS,
  parameter int WP_CYC = (`NFHC_T_WP_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS,
  parameter int HOLD_CYC = (`NFHC_T_HOLD_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS,
  parameter int ACC_CYC = (`NFHC_T_ACC_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire nfhc_pkg::nfhc_cyc_s req,
  input wire logic [`NFHC_DATA_W-1:0] dq_in,
  output nfhc_pkg::nfhc_pins_s pins,
  output logic done,
  output logic [`NFHC_DATA_W-1:0] rdata
);
  import nfhc_pkg::*;

  typedef enum logic [1:0] {
    NFHC_P_IDLE = 2'b00,
    NFHC_P_SETUP = 2'b01,
    NFHC_P_ACT = 2'b10,
    NFHC_P_HOLD = 2'b11
  } nfhc_phase_e;

  typedef struct packed {
    nfhc_phase_e phase;
    logic [3:0] cnt;
    logic rd;
    nfhc_pins_s pins;
    logic done;
    logic [`NFHC_DATA_W-1:0] rdata;
    logic [`NFHC_DATA_W-1:0] sync1;
    logic [`NFHC_DATA_W-1:0] sync2;
  } nfhc_cyc_state_s;

  // Read strobe covers access time plus the two synchroniser stages
  localparam int RD_CYC = ACC_CYC + 2;

  // Phase counters are four bits wide, so every phase must fit 1..16 cycles
  if (SETUP_CYC < 1 || WP_CYC < 1 || HOLD_CYC < 1 || SETUP_CYC > 16
      || HOLD_CYC > 16 || RD_CYC > 16 || WP_CYC > 16)
  begin : g_bad_timing
    $error("nfhc_bus_cycle: timing counts outside 1..16");
  end

  nfhc_cyc_state_s s_reg;
  nfhc_cyc_state_s s_next;

  assign pins = s_reg.pins;
  assign done = s_reg.done;
  assign rdata = s_reg.rdata;

  // Phase sequencing; each phase lasts its count of cycles
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.sync1 = dq_in;
    s_next.sync2 = s_reg.sync1;
    if (s_reg.cnt != 4'h0)
    begin
      s_next.cnt = s_reg.cnt - 4'h1;
    end
    unique case (s_reg.phase)
      NFHC_P_IDLE:
      begin
        if (start)
        begin
          s_next.phase = NFHC_P_SETUP;
          s_next.cnt = 4'(SETUP_CYC - 1);
          s_next.rd = req.rd;
          s_next.pins.ce_n = 1'b0;
          s_next.pins.addr = req.addr;
          s_next.pins.dq_out = req.data;
          s_next.pins.dq_oe = ~req.rd; // Never fight the device on reads
        end
      end
      NFHC_P_SETUP:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          s_next.phase = NFHC_P_ACT;
          s_next.cnt = s_reg.rd ? 4'(RD_CYC - 1) : 4'(WP_CYC - 1);
          s_next.pins.oe_n = ~s_reg.rd;
          s_next.pins.we_n = s_reg.rd;
        end
      end
      NFHC_P_ACT:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          s_next.phase = NFHC_P_HOLD;
          s_next.cnt = 4'(HOLD_CYC - 1);
          s_next.pins.oe_n = 1'b1;
          s_next.pins.we_n = 1'b1; // Rising edge latches the write
          if (s_reg.rd)
          begin
            s_next.rdata = s_reg.sync2;
          end
        end
      end
      NFHC_P_HOLD:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          s_next.phase = NFHC_P_IDLE;
          s_next.pins.ce_n = 1'b1;
          s_next.pins.dq_oe = 1'b0;
          s_next.done = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '{phase: NFHC_P_IDLE, cnt: 4'h0, rd: 1'b0,
        pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0},
        done: 1'b0, rdata: '0, sync1: '0, sync2: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- design/nfhc_flash_host.sv ----
// Host controller for an asynchronous parallel NOR flash: turns user
// commands into the flash's write-cycle sequences and tracks its modes.
// Assumes x16_mode and user ports are on clk; flash pins are external.
//
// Behaviour
// - Chip erase: unlock, unlock, 80, unlock, unlock, 10 at unlock addresses.
// - Block erase ends with 30 at block address; more 30s queue blocks.
// - In bypass, erase and program skip the unlock cycles.
// - After a buffered program abort, reset uses the three-cycle form.
// - Buffered program at most 261/517 cycles, 259/515 in bypass.
// - Written count is units minus one; buffer 256 bytes or 512 words.
// - Host keeps upper address bits fixed during buffered program.
// - Confirm address equals the block address of cycles three and four.
// - Only the two-write bypass reset leaves bypass; F0 does not.
// - Auto select: unlock, unlock, 90 at first unlock address.
`timescale 1ns/100ps
`default_nettype none
`include "nfhc_cfg.svh"
module nfhc_flash_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic x16_mode,
  input wire logic cmd_valid,
  input wire nfhc_pkg::nfhc_req_s cmd_req,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_refused,
  output logic [`NFHC_DATA_W-1:0] rd_data,
  output logic buf_req,
  input wire logic buf_valid,
  input wire logic [`NFHC_ADDR_W-1:0] buf_addr,
  input wire logic [`NFHC_DATA_W-1:0] buf_data,
  output logic bypass_active,
  output logic suspended,
  output logic abort_pending,
  output nfhc_pkg::nfhc_mode_e dev_mode,
  output nfhc_pkg::nfhc_pins_s flash_pins,
  input wire logic [`NFHC_DATA_W-1:0] flash_dq_in
);
  import nfhc_pkg::*;

  typedef enum logic [2:0] {
    NFHC_S_IDLE = 3'b000,
    NFHC_S_ISSUE = 3'b001,
    NFHC_S_WAIT = 3'b010,
    NFHC_S_BDATA = 3'b011,
    NFHC_S_BWAIT = 3'b100
  } nfhc_state_e;

  typedef struct packed {
    nfhc_state_e st;
    nfhc_req_s req;
    logic [2:0] idx;
    logic [8:0] left;
    logic long_rst;
    logic bypass;
    logic susp;
    nfhc_mode_e mode;
    logic abort_pend;
    logic last_buf;
    logic cyc_start;
    nfhc_cyc_s cyc;
    logic ready;
    logic done;
    logic refused;
    logic [`NFHC_DATA_W-1:0] rdata;
    logic breq;
  } nfhc_host_state_s;

  nfhc_host_state_s s_reg;
  nfhc_host_state_s s_next;
  logic cyc_done;
  logic [`NFHC_DATA_W-1:0] cyc_rdata;

  // Outputs are fields of the state register
  assign cmd_ready = s_reg.ready;
  assign cmd_done = s_reg.done;
  assign cmd_refused = s_reg.refused;
  assign rd_data = s_reg.rdata;
  assign buf_req = s_reg.breq;
  assign bypass_active = s_reg.bypass;
  assign suspended = s_reg.susp;
  assign abort_pending = s_reg.abort_pend;
  assign dev_mode = s_reg.mode;

  // Last step index of each command's write sequence
  function automatic logic [2:0] last_idx(input nfhc_cmd_e c);
    unique case (c)
      NFHC_BYP_EXIT, NFHC_PROGRAM: last_idx = 3'd3;
      NFHC_BUF_PROG: last_idx = 3'd4;
      NFHC_CHIP_ERASE, NFHC_BLOCK_ERASE: last_idx = 3'd5;
      NFHC_BLANK: last_idx = 3'd6;
      default: last_idx = 3'd2;
    endcase
  endfunction

  // Commands whose unlock cycles bypass mode drops
  function automatic logic bypassable(input nfhc_cmd_e c);
    bypassable = (c == NFHC_PROGRAM) || (c == NFHC_BUF_PROG)
      || (c == NFHC_CHIP_ERASE) || (c == NFHC_BLOCK_ERASE);
  endfunction

  // Address and data of step i; steps 0 and 1 are the shared unlocks
  function automatic nfhc_cyc_s step_of(input nfhc_req_s r, input logic [2:0] i,
                                        input logic x16);
    logic [`NFHC_ADDR_W-1:0] u1;
    logic [`NFHC_ADDR_W-1:0] u2;
    logic [7:0] code;
    nfhc_cyc_s c;
    u1 = x16 ? `NFHC_U1_X16 : `NFHC_U1_X8;
    u2 = x16 ? `NFHC_U2_X16 : `NFHC_U2_X8;
    code = `NFHC_C_ZERO;
    c = '{rd: 1'b0, addr: u1, data: '0};
    if (i == 3'd0)
    begin
      code = `NFHC_C_UNLK1;
    end
    else if (i == 3'd1)
    begin
      c.addr = u2;
      code = `NFHC_C_UNLK2;
    end
    else
    begin
      unique case (r.cmd)
        NFHC_RESET: code = `NFHC_C_RESET;
        NFHC_CFI: code = `NFHC_C_CFI;
        NFHC_ASEL: code = `NFHC_C_ASEL;
        NFHC_BYP_ENTER: code = `NFHC_C_BYP;
        NFHC_BYP_EXIT: code = (i == 3'd2) ? `NFHC_C_BYPX0 : `NFHC_C_BYPX1;
        NFHC_SUSPEND: code = `NFHC_C_SUSP;
        NFHC_RESUME: code = `NFHC_C_RESUME;
        NFHC_PROGRAM:
        begin
          code = `NFHC_C_PROG;
          if (i == 3'd3)
          begin
            c.addr = r.addr;
            c.data = r.data;
          end
        end
        NFHC_BUF_PROG:
        begin
          c.addr = r.addr;
          code = (i == 3'd2) ? `NFHC_C_BUF : `NFHC_C_CONF;
          if (i == 3'd3)
          begin
            c.data = {7'h00, r.count};
          end
        end
        NFHC_CHIP_ERASE, NFHC_BLOCK_ERASE:
        begin
          unique case (i)
            3'd2: code = `NFHC_C_ERASE;
            3'd3: code = `NFHC_C_UNLK1;
            3'd4:
            begin
              c.addr = u2;
              code = `NFHC_C_UNLK2;
            end
            default:
            begin
              if (r.cmd == NFHC_BLOCK_ERASE)
              begin
                c.addr = r.addr;
                code = `NFHC_C_BLOCK;
              end
              else
              begin
                code = `NFHC_C_CHIP;
              end
            end
          endcase
        end
        NFHC_ERASE_MORE:
        begin
          c.addr = r.addr;
          code = `NFHC_C_BLOCK;
        end
        NFHC_BLANK:
        begin
          c.addr = r.addr;
          unique case (i)
            3'd2: code = `NFHC_C_EXT;
            3'd3: code = `NFHC_C_BLANK;
            3'd6: code = `NFHC_C_CONF;
            default: code = `NFHC_C_ZERO;
          endcase
        end
        NFHC_READ:
        begin
          c.rd = 1'b1;
          c.addr = r.addr;
        end
        default: code = `NFHC_C_ZERO;
      endcase
    end
    if (!c.rd && !(r.cmd == NFHC_PROGRAM && i == 3'd3) && !(r.cmd == NFHC_BUF_PROG && i == 3'd3))
    begin
      c.data = {8'h00, code};
    end
    step_of = c;
  endfunction

  // Refusal checks against the host's view of the device
  function automatic logic refuse(input nfhc_req_s r, input nfhc_host_state_s s,
                                  input logic x16);
    logic prog_class;
    prog_class = bypassable(r.cmd) || (r.cmd == NFHC_BLANK)
      || (r.cmd == NFHC_ERASE_MORE);
    unique case (r.cmd)
      NFHC_CFI: refuse = (s.mode == NFHC_M_CFI) || s.bypass;
      NFHC_BYP_ENTER: refuse = s.bypass || (s.mode != NFHC_M_ARRAY);
      NFHC_BYP_EXIT: refuse = !s.bypass;
      NFHC_ASEL: refuse = s.bypass || (s.mode == NFHC_M_CFI);
      NFHC_BUF_PROG: refuse = (s.mode != NFHC_M_ARRAY) || s.abort_pend
        || (r.count > (x16 ? `NFHC_BUF_MAX_X16 : `NFHC_BUF_MAX_X8));
      default: refuse = prog_class && ((s.mode != NFHC_M_ARRAY) || s.abort_pend);
    endcase
  endfunction

  // Command sequencer and mode tracking
  always_comb
  begin
    logic [`NFHC_ADDR_W-1:0] mask;
    mask = x16_mode ? `NFHC_PAGE_MASK_X16 : `NFHC_PAGE_MASK_X8;
    s_next = s_reg;
    s_next.cyc_start = 1'b0;
    s_next.done = 1'b0;
    s_next.refused = 1'b0;
    unique case (s_reg.st)
      NFHC_S_IDLE:
      begin
        if (cmd_valid && s_reg.ready)
        begin
          if (refuse(cmd_req, s_reg, x16_mode))
          begin
            s_next.refused = 1'b1;
          end
          else
          begin
            s_next.req = cmd_req;
            s_next.ready = 1'b0;
            s_next.st = NFHC_S_ISSUE;
            s_next.long_rst = s_reg.abort_pend;
            // Single-write commands and bypass forms start past the unlocks
            if (cmd_req.cmd == NFHC_RESET)
            begin
              s_next.idx = s_reg.abort_pend ? 3'd0 : 3'd2;
            end
            else if (cmd_req.cmd == NFHC_ASEL || cmd_req.cmd == NFHC_BYP_ENTER
                     || cmd_req.cmd == NFHC_BLANK)
            begin
              s_next.idx = 3'd0;
            end
            else if (bypassable(cmd_req.cmd))
            begin
              s_next.idx = s_reg.bypass ? 3'd2 : 3'd0;
            end
            else
            begin
              s_next.idx = 3'd2;
            end
          end
        end
      end
      NFHC_S_ISSUE:
      begin
        s_next.cyc = step_of(s_reg.req, s_reg.idx, x16_mode);
        s_next.cyc_start = 1'b1;
        s_next.st = NFHC_S_WAIT;
      end
      NFHC_S_WAIT:
      begin
        if (cyc_done)
        begin
          if (s_reg.cyc.rd)
          begin
            s_next.rdata = cyc_rdata;
            if (s_reg.last_buf && cyc_rdata[`NFHC_ABORT_BIT])
            begin
              s_next.abort_pend = 1'b1;
            end
          end
          if (s_reg.req.cmd == NFHC_BUF_PROG && s_reg.idx == 3'd3)
          begin
            s_next.left = s_reg.req.count;
            s_next.breq = 1'b1;
            s_next.st = NFHC_S_BDATA;
          end
          else if (s_reg.idx == last_idx(s_reg.req.cmd))
          begin
            s_next.st = NFHC_S_IDLE;
            s_next.ready = 1'b1;
            s_next.done = 1'b1;
            unique case (s_reg.req.cmd)
              NFHC_RESET:
              begin
                s_next.mode = NFHC_M_ARRAY;
                if (s_reg.long_rst)
                begin
                  s_next.abort_pend = 1'b0;
                end
              end
              NFHC_CFI: s_next.mode = NFHC_M_CFI;
              NFHC_ASEL: s_next.mode = NFHC_M_ASEL;
              NFHC_BYP_ENTER: s_next.bypass = 1'b1;
              NFHC_BYP_EXIT: s_next.bypass = 1'b0;
              NFHC_SUSPEND: s_next.susp = 1'b1;
              NFHC_RESUME: s_next.susp = 1'b0;
              default: s_next.mode = s_reg.mode;
            endcase
            if (s_reg.req.cmd != NFHC_READ)
            begin
              s_next.last_buf = (s_reg.req.cmd == NFHC_BUF_PROG);
            end
          end
          else if (s_reg.bypass && s_reg.idx == 3'd2
                   && (s_reg.req.cmd == NFHC_CHIP_ERASE
                       || s_reg.req.cmd == NFHC_BLOCK_ERASE))
          begin
            s_next.idx = 3'd5;
            s_next.st = NFHC_S_ISSUE;
          end
          else
          begin
            s_next.idx = s_reg.idx + 3'd1;
            s_next.st = NFHC_S_ISSUE;
          end
        end
      end
      NFHC_S_BDATA:
      begin
        // Upper bits forced from the block address so the page cannot move
        if (buf_valid && s_reg.breq)
        begin
          s_next.breq = 1'b0;
          s_next.cyc.rd = 1'b0;
          s_next.cyc.addr = (s_reg.req.addr & ~mask) | (buf_addr & mask);
          s_next.cyc.data = buf_data;
          s_next.cyc_start = 1'b1;
          s_next.st = NFHC_S_BWAIT;
        end
      end
      NFHC_S_BWAIT:
      begin
        if (cyc_done)
        begin
          if (s_reg.left == 9'h000)
          begin
            s_next.idx = 3'd4;
            s_next.st = NFHC_S_ISSUE;
          end
          else
          begin
            s_next.left = s_reg.left - 9'h001;
            s_next.breq = 1'b1;
            s_next.st = NFHC_S_BDATA;
          end
        end
      end
      default:
      begin
        s_next.st = NFHC_S_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
  end

  // State register; the flash is assumed in read array after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '{st: NFHC_S_IDLE, req: '0, idx: 3'd0, left: 9'h000, long_rst: 1'b0,
        bypass: 1'b0, susp: 1'b0, mode: NFHC_M_ARRAY, abort_pend: 1'b0,
        last_buf: 1'b0, cyc_start: 1'b0, cyc: '0, ready: 1'b1, done: 1'b0,
        refused: 1'b0, rdata: '0, breq: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Pin-level cycle engine
  nfhc_bus_cycle u_cycle (
    .clk(clk),
    .reset(reset),
    .start(s_reg.cyc_start),
    .req(s_reg.cyc),
    .dq_in(flash_dq_in),
    .pins(flash_pins),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );
endmodule
`default_nettype wire

// ---- dv/nfhc_checker.sv ----
// Assertions on the ports of nfhc_flash_host.
// Assumes one clock domain and the mode encoding of nfhc_pkg.
`timescale 1ns/100ps
`default_nettype none
module nfhc_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire nfhc_pkg::nfhc_req_s cmd_req,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic cmd_refused,
  input wire logic bypass_active,
  input wire logic abort_pending,
  input wire nfhc_pkg::nfhc_mode_e dev_mode,
  input wire nfhc_pkg::nfhc_pins_s flash_pins
);
  import nfhc_pkg::*;
  nfhc_cmd_e last_reg;
  wire logic take = cmd_valid && cmd_ready;
  // Last taken command explains every later state change
  always_ff @(posedge clk or posedge reset)
    if (reset) last_reg <= NFHC_READ;
    else if (take) last_reg <= cmd_req.cmd;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_boot;
    $fell(reset) |-> cmd_ready && flash_pins.ce_n && dev_mode == NFHC_M_ARRAY;
  endproperty
  a_boot: assert property (p_boot) else $error("bad state after reset");
  property p_pulse;
    cmd_done || cmd_refused |=> !cmd_done && !cmd_refused;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer pulse too long");
  property p_silent;
    cmd_refused |-> flash_pins.ce_n && flash_pins.we_n;
  endproperty
  a_silent: assert property (p_silent) else $error("refused but bus active");
  property p_cfi_ref;
    take && cmd_req.cmd == NFHC_CFI && (bypass_active || dev_mode == NFHC_M_CFI) |=> cmd_refused;
  endproperty
  a_cfi_ref: assert property (p_cfi_ref) else $error("query not refused");
  property p_byp;
    $fell(bypass_active) |-> last_reg == NFHC_BYP_EXIT;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass left wrongly");
  property p_mode;
    $past(dev_mode) != dev_mode && $past(dev_mode) != NFHC_M_ARRAY
      |-> last_reg inside {NFHC_RESET, NFHC_CFI};
  endproperty
  a_mode: assert property (p_mode) else $error("mode left wrongly");
  property p_abort;
    take && abort_pending && cmd_req.cmd inside {NFHC_PROGRAM, NFHC_BUF_PROG, NFHC_CHIP_ERASE}
      |=> cmd_refused;
  endproperty
  a_abort: assert property (p_abort) else $error("write after abort taken");
  property p_abort_clr;
    $fell(abort_pending) |-> last_reg == NFHC_RESET;
  endproperty
  a_abort_clr: assert property (p_abort_clr) else $error("abort cleared wrongly");
  property p_strobe;
    $fell(flash_pins.we_n) |-> !flash_pins.ce_n && !flash_pins.we_n [*4] ##1 flash_pins.we_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe width");
  c_buf: cover property (take && cmd_req.cmd == NFHC_BUF_PROG);
  c_byp: cover property ($rose(bypass_active));
  c_abort: cover property ($rose(abort_pending));
endmodule
bind nfhc_flash_host nfhc_checker u_chk (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_req(cmd_req), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
  .bypass_active(bypass_active), .abort_pending(abort_pending), .dev_mode(dev_mode),
  .flash_pins(flash_pins));
`default_nettype wire

// ---- dv/nfhc_flash_model.sv ----
// Behavioural flash device: logs and decodes writes, answers reads.
// Assumes a clean strobe per cycle; busy time is not modelled.
`timescale 1ns/100ps
`default_nettype none
module nfhc_flash_model #(
  parameter logic [15:0] ID_VAL = 16'h0042, // Arbitrary value
  parameter logic [15:0] CFI_VAL = 16'h0051
)(
  input wire nfhc_pkg::nfhc_pins_s pins,
  input wire logic abort_set,
  output logic [15:0] dq
);
  logic [23:0] la [0:63];
  logic [15:0] ld [0:63];
  int lc = 0;
  logic [7:0] p1 = 8'h00;
  logic [7:0] p2 = 8'h00;
  logic [1:0] mode = 2'd0;
  logic abort = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] ans;
  // Decode on the rising strobe, only while selected
  always @(posedge pins.we_n)
    if (!pins.ce_n)
    begin
      la[lc] = pins.addr;
      ld[lc] = pins.dq_out;
      lc++;
      if (pins.dq_out[7:0] == 8'h98 && mode != 2'd2) mode = 2'd2;
      else if (pins.dq_out[7:0] == 8'hF0)
      begin
        mode = 2'd0;
        if (p1 == 8'h55 && p2 == 8'hAA) abort = 1'b0;
      end
      else if (pins.dq_out[7:0] == 8'h90 && p1 == 8'h55) mode = 2'd1;
      p2 = p1;
      p1 = pins.dq_out[7:0];
    end
  always @(posedge abort_set) abort = 1'b1;
  // Released bus shows the inverse, never a stale copy
  assign ans = mode == 2'd2 ? CFI_VAL : mode == 2'd1 ? ID_VAL : {14'h0000, abort, 1'b0};
  always @(posedge pins.oe_n) last = ans;
  assign dq = (!pins.ce_n && !pins.oe_n) ? ans : ~last;
endmodule
`default_nettype wire

// ---- dv/nfhc_flash_host_tb.sv ----
// Bench of nfhc_flash_host against the flash model.
// Assumes the model logs every write strobe it sees.
`timescale 1ns/100ps
`default_nettype none
`include "nfhc_cfg.svh"
module nfhc_flash_host_tb;
  import nfhc_pkg::*;
  localparam logic [15:0] ID = 16'h0042; // Arbitrary value
  localparam logic [23:0] BA = 24'h02_0000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic x16_mode = 1'b1;
  logic cmd_valid = 1'b0;
  nfhc_req_s cmd_req = '0;
  logic buf_valid = 1'b0;
  logic abort_set = 1'b0;
  logic [8:0] bcnt = 9'h000;
  logic cmd_ready, cmd_done, cmd_refused, buf_req, bypass_active, suspended, abort_pending;
  logic [15:0] rd_data, dq;
  nfhc_mode_e dev_mode;
  nfhc_pins_s pins;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int base = 0;
  wire logic [23:0] u1 = x16_mode ? `NFHC_U1_X16 : `NFHC_U1_X8;
  wire logic [23:0] u2 = x16_mode ? `NFHC_U2_X16 : `NFHC_U2_X8;
  always #5 clk = ~clk;
  nfhc_flash_host uut (.clk(clk), .reset(reset), .x16_mode(x16_mode), .cmd_valid(cmd_valid),
    .cmd_req(cmd_req), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
    .rd_data(rd_data), .buf_req(buf_req), .buf_valid(buf_valid), .buf_addr({15'h0000, bcnt}),
    .buf_data({7'h50, bcnt}), .bypass_active(bypass_active), .suspended(suspended),
    .abort_pending(abort_pending), .dev_mode(dev_mode), .flash_pins(pins), .flash_dq_in(dq));
  nfhc_flash_model #(.ID_VAL(ID)) fm (.pins(pins), .abort_set(abort_set), .dq(dq));
  // Unit offer; data and address step per accepted unit
  always @(posedge clk)
  begin
    if (buf_valid && buf_req) bcnt <= bcnt + 9'h001;
    buf_valid <= buf_req;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic b1(input string nm, input logic e, input logic g);
    chk(nm, {23'h0, e}, {23'h0, g});
  endtask
  task automatic md(input nfhc_mode_e e);
    chk("dev_mode", {22'h0, e}, {22'h0, dev_mode});
  endtask
  task automatic wd(input int k, input logic [15:0] d);
    chk("wr data", {8'h00, d}, {8'h00, fm.ld[base + k]});
  endtask
  task automatic wr(input int k, input logic [23:0] a, input logic [15:0] d);
    chk("wr addr", a, fm.la[base + k]);
    wd(k, d);
  endtask
  // Present, hold until taken, wait for the answer
  task automatic issue(input nfhc_cmd_e c, input logic [23:0] a, input logic [8:0] n,
    input logic r, input int w);
    int i;
    logic rf;
    base = fm.lc;
    rf = 1'b0;
    cmd_req <= '{cmd: c, addr: a, data: 16'h3C5A, count: n};
    cmd_valid <= 1'b1;
    @(posedge clk);
    while (!cmd_ready) @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 3000 && !cmd_done && !rf; i++)
    begin
      @(posedge clk);
      rf = cmd_refused;
    end
    b1("refused", r, rf);
    b1("done", ~r, cmd_done);
    chk("writes", 24'(w), 24'(fm.lc - base));
  endtask
  task automatic t_erase();
    issue(NFHC_RESET, BA, 9'h000, 1'b0, 1);
    wr(0, u1, 16'h00F0);
    issue(NFHC_CHIP_ERASE, BA, 9'h000, 1'b0, 6);
    wr(0, u1, 16'h00AA);
    wr(1, u2, 16'h0055);
    wr(2, u1, 16'h0080);
    wr(3, u1, 16'h00AA);
    wr(4, u2, 16'h0055);
    wr(5, u1, 16'h0010);
    issue(NFHC_BLOCK_ERASE, BA, 9'h000, 1'b0, 6);
    wr(5, BA, 16'h0030);
    issue(NFHC_ERASE_MORE, BA + 24'h01_0000, 9'h000, 1'b0, 1);
    wr(0, BA + 24'h01_0000, 16'h0030);
  endtask
  task automatic t_bypass();
    issue(NFHC_BYP_ENTER, BA, 9'h000, 1'b0, 3);
    wr(2, u1, 16'h0020);
    issue(NFHC_CHIP_ERASE, BA, 9'h000, 1'b0, 2);
    wd(1, 16'h0010);
    issue(NFHC_BLOCK_ERASE, BA, 9'h000, 1'b0, 2);
    wr(1, BA, 16'h0030);
    issue(NFHC_CFI, BA, 9'h000, 1'b1, 0);
    issue(NFHC_RESET, BA, 9'h000, 1'b0, 1);
    b1("bypass", 1'b1, bypass_active);
    issue(NFHC_BYP_EXIT, BA, 9'h000, 1'b0, 2);
    wd(0, 16'h0090);
    b1("bypass", 1'b0, bypass_active);
  endtask
  task automatic t_modes();
    x16_mode <= 1'b0;
    issue(NFHC_ASEL, BA, 9'h000, 1'b0, 3);
    wr(0, 24'h00_0AAA, 16'h00AA);
    wr(2, 24'h00_0AAA, 16'h0090);
    issue(NFHC_READ, 24'h00_0001, 9'h000, 1'b0, 0);
    chk("id", {8'h00, ID}, {8'h00, rd_data});
    issue(NFHC_CFI, BA, 9'h000, 1'b0, 1);
    md(NFHC_M_CFI);
    issue(NFHC_READ, 24'h00_0010, 9'h000, 1'b0, 0);
    chk("cfi", 24'h00_0051, {8'h00, rd_data});
    issue(NFHC_BUF_PROG, BA, 9'h100, 1'b1, 0);
    issue(NFHC_RESET, BA, 9'h000, 1'b0, 1);
    md(NFHC_M_ARRAY);
    issue(NFHC_BUF_PROG, BA, 9'h100, 1'b1, 0);
    x16_mode <= 1'b1;
  endtask
  task automatic t_buf();
    issue(NFHC_BUF_PROG, BA, 9'h001, 1'b0, 7);
    wr(3, BA, 16'h0001);
    wr(4, BA, 16'hA000);
    wr(5, BA + 24'h1, 16'hA001);
    wr(6, BA, 16'h0029);
    abort_set <= 1'b1;
    issue(NFHC_READ, BA, 9'h000, 1'b0, 0);
    b1("abort", 1'b1, abort_pending);
    issue(NFHC_PROGRAM, BA, 9'h000, 1'b1, 0);
    issue(NFHC_RESET, BA, 9'h000, 1'b0, 3);
    wr(1, u2, 16'h0055);
    b1("abort", 1'b0, abort_pending);
    issue(NFHC_SUSPEND, BA, 9'h000, 1'b0, 1);
    b1("suspended", 1'b1, suspended);
    issue(NFHC_RESUME, BA, 9'h000, 1'b0, 1);
    wd(0, 16'h0030);
    issue(NFHC_BLANK, BA, 9'h000, 1'b0, 7);
    wr(3, BA, 16'h0076);
    wr(6, BA, 16'h0029);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycle ceiling far above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    md(NFHC_M_ARRAY);
    t_erase();
    t_bypass();
    t_modes();
    t_buf();
    conclude();
  end
endmodule
`default_nettype wire
